// ===== inc/tms_pkg.sv
// constants, register map and state encoding for the tabulated motion sequencer
// assumes a 20 MHz system clock and a fixed control sample period
package tms_pkg;
    // ==========================================================
    // timing
    localparam int unsigned TMS_CLK_NS     = 50;
    localparam int unsigned TMS_SAMPLE_US  = 160;
    localparam int unsigned TMS_SAMPLE_CYC = TMS_SAMPLE_US * 1000 / TMS_CLK_NS;
    localparam logic [31:0] TMS_NS_PER_MS  = 32'h000F_4240;
    localparam logic signed [39:0] TMS_MS_PER_S = 40'sh00_0000_03E8;
    localparam int          TMS_UFRAC      = 16;
    // ==========================================================
    // table and limits
    localparam int unsigned TMS_ROWS    = 64;
    localparam int          TMS_RW      = 7;
    localparam int          TMS_AW      = 8;
    localparam logic signed [31:0] TMS_POS_LIM = 32'sh4000_0000;
    localparam logic [10:0] TMS_PDO_BASE = 11'h300;
    // ==========================================================
    // register offsets
    localparam logic [7:0] REG_MOTOR  = 8'h00;
    localparam logic [7:0] REG_CMD    = 8'h04;
    localparam logic [7:0] REG_START  = 8'h08;
    localparam logic [7:0] REG_LOW    = 8'h0C;
    localparam logic [7:0] REG_HIGH   = 8'h10;
    localparam logic [7:0] REG_MODE   = 8'h14;
    localparam logic [7:0] REG_QLOW   = 8'h18;
    localparam logic [7:0] REG_WPTR   = 8'h1C;
    localparam logic [7:0] REG_SDEC   = 8'h20;
    localparam logic [7:0] REG_STATUS = 8'h24;
    localparam logic [7:0] REG_CIDX   = 8'h28;
    localparam logic [7:0] REG_CPOS   = 8'h2C;
    localparam logic [7:0] REG_CSPD   = 8'h30;
    localparam logic [7:0] REG_CTIM   = 8'h34;
    localparam logic [7:0] REG_POSREF = 8'h38;
    localparam logic [7:0] REG_NODE   = 8'h3C;
    // ==========================================================
    // field positions, emergency codes and state encoding
    localparam int CMD_BEGIN = 0;
    localparam int CMD_OTHER = 1;
    localparam int MODE_CYC  = 0;
    localparam int MODE_AUTO = 1;
    localparam int STS_RUN   = 0;
    localparam int STS_ARMED = 1;
    localparam int STS_STOP  = 2;
    localparam int STS_CERR  = 3;
    localparam int STS_REJ   = 4;
    localparam int STS_UFLOW = 5;
    localparam logic [1:0] EMCY_QLOW   = 2'h1;
    localparam logic [1:0] EMCY_UFLOW  = 2'h2;
    localparam logic [1:0] EMCY_REJECT = 2'h3;
    typedef enum logic [2:0] {
        ST_IDLE, ST_ARMED, ST_LOAD, ST_WAIT, ST_DIV, ST_EVAL, ST_STOP
    } tms_state_t;
endpackage : tms_pkg

// ===== hdl/tms_sequencer.sv
// tabulated position-speed-time sequencer: table, read/write pointers, cubic path
// assumes pdo_* come from same-clock CAN logic; fault_in is an asynchronous pin
// Contract
// [RULE1] table of 64 rows: 32-bit position, 24-bit speed, 8-bit time
// [RULE2] indexed cell registers write and read any row's position, speed or time
// [RULE3] positions saturate to plus or minus two to the thirtieth
// [RULE4] speeds are held within plus or minus two to the twenty-third
// [RULE5] row times lie in 1..255 ms; zero is raised to one
// [RULE6] segment at pointer N runs from row N to row N+1
// [RULE7] when row N time elapses pointer steps and next pair is loaded
// [RULE8] path is evaluated each sample; leftover time carries into next segment
// [RULE9] lowest and highest valid rows are programmable
// [RULE10] non-cyclic stops at highest row; cyclic continues from lowest row
// [RULE11] cyclic next row wraps within the valid range
// [RULE12] start row 1..64 loads pointer and arms; begin then starts motion
// [RULE13] writing rows of the executing segment is refused and flagged
// [RULE14] motor off or an exception ends tabulated motion
// [RULE15] another motion mode ends tabulated motion at once
// [RULE16] running out of data stops using stop deceleration
// [RULE17] a whole row arrives in one message at 0x300 plus node id
// [RULE18] message rows go to the write pointer, which then auto-increments
// [RULE19] emergency when unexecuted rows fall below the threshold; the code checks this only in auto mode while motion runs
// [RULE20] auto mode underflow is read pointer reaching write pointer; emergency sent
// [RULE21] host maps the row message correctly before use
// [RULE22] cubic interpolation matches end positions and speeds
// [RULE23] positions and speeds absolute, times relative
// [RULE24] threshold gives warning row count; zero disables it
// [RULE25] elapsed-time accumulator advanced by the sample period
// [RULE26] coefficients computed before the first sample of each segment
//
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module tms_sequencer #(
    parameter int unsigned ROWS       = tms_pkg::TMS_ROWS,
    parameter int unsigned SAMPLE_CYC = tms_pkg::TMS_SAMPLE_CYC
) (
    input  wire logic                        clk_sys,
    input  wire logic                        rstn,
    input  wire logic                        ce,
    input  wire logic [tms_pkg::TMS_AW-1:0]  reg_addr,
    input  wire logic [31:0]                 reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic      [31:0]                 reg_rdata,
    input  wire logic                        pdo_valid,
    input  wire logic [10:0]                 pdo_cob_id,
    input  wire logic [31:0]                 pdo_pos,
    input  wire logic [23:0]                 pdo_spd,
    input  wire logic [7:0]                  pdo_tim,
    input  wire logic                        fault_in,
    output logic      [31:0]                 pos_ref,
    output logic                             motion_active,
    output logic                             emcy_valid,
    output logic      [1:0]                  emcy_code,
    output logic      [tms_pkg::TMS_RW-1:0]  emcy_rptr,
    output logic      [tms_pkg::TMS_RW-1:0]  emcy_wptr
);
    import tms_pkg::*;

    localparam int IW = $clog2(ROWS);
    localparam logic [31:0] SAMPLE_NS = 32'(SAMPLE_CYC * TMS_CLK_NS);
    localparam logic [31:0] TICK_LAST = 32'(SAMPLE_CYC - 1);
    localparam logic [4:0]  DIV_LAST  = 5'(TMS_UFRAC - 1);

    // ==========================================================
    // state
    typedef struct packed {
        tms_state_t                st;
        logic [ROWS-1:0][31:0]     tpos;
        logic [ROWS-1:0][23:0]     tspd;
        logic [ROWS-1:0][7:0]      ttim;
        logic                      motor_on;
        logic                      cyclic;
        logic                      auto_inc;
        logic [IW-1:0]             low;
        logic [IW-1:0]             high;
        logic [IW-1:0]             rptr;
        logic [IW-1:0]             wptr;
        logic [IW-1:0]             cidx;
        logic [IW:0]               qthr;
        logic [15:0]               sdec;
        logic [6:0]                node;
        logic                      cell_err;
        logic                      rej_err;
        logic                      uflow;
        logic                      qlow_seen;
        logic [31:0]               scnt;
        logic [31:0]               elap;
        logic [31:0]               tns;
        logic [32:0]               rem;
        logic [15:0]               quo;
        logic [4:0]                dcnt;
        logic signed [39:0]        ca;
        logic signed [39:0]        cb;
        logic signed [39:0]        cc;
        logic [31:0]               cd;
        logic [31:0]               pos;
        logic [31:0]               vel;
        logic [31:0]               rdata;
        logic                      ev;
        logic [1:0]                ecode;
        logic [TMS_RW-1:0]         erp;
        logic [TMS_RW-1:0]         ewp;
        logic [1:0]                flt;
    } tms_regs_t;

    // ==========================================================
    // functions
    function automatic logic [IW-1:0] nxt(input logic [IW-1:0] r, lo, hi);
        return (r == hi) ? lo : IW'(r + 1'b1);
    endfunction : nxt

    function automatic logic row_ok(input logic [31:0] v);
        return (v != '0) && (v <= 32'(ROWS));
    endfunction : row_ok

    function automatic logic [IW-1:0] to_idx(input logic [31:0] v);
        return IW'(v - 32'h1);
    endfunction : to_idx

    function automatic logic [31:0] sat_pos(input logic [31:0] v);
        if ($signed(v) > TMS_POS_LIM) return TMS_POS_LIM;
        if ($signed(v) < -TMS_POS_LIM) return -TMS_POS_LIM;
        return v;
    endfunction : sat_pos

    function automatic logic [7:0] fix_tim(input logic [7:0] t);
        return (t == '0) ? 8'h01 : t;
    endfunction : fix_tim

    // speed (counts/s) times duration (ms) gives counts over the segment
    function automatic logic signed [39:0] vsc(input logic [23:0] v, input logic [7:0] t);
        logic signed [39:0] p;
        p = 40'($signed(v)) * 40'($signed({1'b0, t}));
        return p / TMS_MS_PER_S;
    endfunction : vsc

    // horner form over normalised time u in [0,1)
    function automatic logic signed [63:0] poly(input logic signed [39:0] a, b, c,
                                                input logic [31:0] dd, input logic [15:0] u);
        logic signed [63:0] h;
        logic signed [63:0] us;
        us = $signed({48'h0, u});
        h  = 64'(a);
        h  = ((h * us) >>> TMS_UFRAC) + 64'(b);
        h  = ((h * us) >>> TMS_UFRAC) + 64'(c);
        h  = ((h * us) >>> TMS_UFRAC) + 64'($signed(dd));
        return h;
    endfunction : poly

    function automatic tms_regs_t rst_val();
        tms_regs_t r;
        r      = '0;
        r.st   = ST_IDLE;
        r.high = IW'(ROWS - 1);
        for (int i = 0; i < ROWS; i++) begin
            r.ttim[i] = 8'h01;
        end
        return r;
    endfunction : rst_val

    localparam tms_regs_t RST_Q = rst_val();

    tms_regs_t q;
    tms_regs_t d;

    // ==========================================================
    // decode
    logic          tick, running, adv, adv_end, adv_uf, pdo_take, pdo_bad, cell_bad;
    logic [IW-1:0] r_nxt;
    logic [31:0]   elap_n;
    logic [IW:0]   span, remain;

    assign tick     = (q.scnt == TICK_LAST);
    assign running  = (q.st == ST_LOAD) || (q.st == ST_WAIT) || (q.st == ST_DIV)
                   || (q.st == ST_EVAL);
    assign r_nxt    = nxt(q.rptr, q.low, q.high); // RULE6 RULE11
    assign elap_n   = q.elap + SAMPLE_NS; // RULE25
    assign adv      = (q.st == ST_WAIT) && tick && (elap_n >= q.tns); // RULE7
    assign adv_end  = !q.cyclic && (r_nxt == q.high); // RULE10
    assign adv_uf   = q.auto_inc && (r_nxt == q.wptr); // RULE20
    // the row message is taken as already mapped to position, speed, time
    assign pdo_take = pdo_valid && (pdo_cob_id == TMS_PDO_BASE + {4'h0, q.node}); // RULE17 RULE21
    assign pdo_bad  = running && ((q.wptr == q.rptr) || (q.wptr == r_nxt)); // RULE13
    assign cell_bad = running && ((q.cidx == q.rptr) || (q.cidx == r_nxt)); // RULE13
    assign span     = {1'b0, q.high} - {1'b0, q.low} + 1'b1;
    assign remain   = (q.wptr >= q.rptr) ? {1'b0, q.wptr} - {1'b0, q.rptr}
                    : {1'b0, q.wptr} + span - {1'b0, q.rptr};

    // ==========================================================
    // next state
    always_comb begin
        logic [32:0]        r2;
        logic signed [39:0] dp, v0t, v1t;
        logic signed [63:0] p;
        logic signed [31:0] nv;
        r2 = '0;
        dp = '0;
        v0t = '0;
        v1t = '0;
        p = '0;
        nv = '0;
        d = q;
        d.ev = 1'b0;
        d.rdata = '0;
        d.flt = {q.flt[0], fault_in};
        d.scnt = tick ? '0 : q.scnt + 32'h1;

        // w1c clear first so that any set in this cycle wins
        if (reg_wr && reg_addr == REG_STATUS) begin
            if (reg_wdata[STS_CERR]) d.cell_err = 1'b0;
            if (reg_wdata[STS_REJ]) d.rej_err = 1'b0;
            if (reg_wdata[STS_UFLOW]) d.uflow = 1'b0;
        end

        if (pdo_take) begin
            if (pdo_bad) begin
                d.rej_err = 1'b1; // RULE13
                d.ev = 1'b1;
                d.ecode = EMCY_REJECT;
            end else begin
                d.tpos[q.wptr] = sat_pos(pdo_pos); // RULE18 RULE3
                d.tspd[q.wptr] = pdo_spd; // RULE4
                d.ttim[q.wptr] = fix_tim(pdo_tim); // RULE5
                d.wptr = nxt(q.wptr, q.low, q.high); // RULE18
            end
        end

        if (reg_wr) begin
            unique case (reg_addr)
                REG_MOTOR: d.motor_on = reg_wdata[0];
                REG_START: if (row_ok(reg_wdata)) begin
                    d.rptr = to_idx(reg_wdata); // RULE12
                    d.st = ST_ARMED;
                end
                REG_LOW:  if (row_ok(reg_wdata)) d.low = to_idx(reg_wdata); // RULE9
                REG_HIGH: if (row_ok(reg_wdata)) d.high = to_idx(reg_wdata); // RULE9
                REG_MODE: begin
                    d.cyclic = reg_wdata[MODE_CYC];
                    d.auto_inc = reg_wdata[MODE_AUTO];
                end
                REG_QLOW: d.qthr = reg_wdata[IW:0];
                REG_WPTR: if (row_ok(reg_wdata)) d.wptr = to_idx(reg_wdata);
                REG_SDEC: d.sdec = reg_wdata[15:0];
                REG_NODE: d.node = reg_wdata[6:0];
                REG_CIDX: if (row_ok(reg_wdata)) d.cidx = to_idx(reg_wdata); // RULE2
                REG_CPOS: if (cell_bad) d.cell_err = 1'b1; // RULE13
                    else d.tpos[q.cidx] = sat_pos(reg_wdata); // RULE2 RULE3
                REG_CSPD: if (cell_bad) d.cell_err = 1'b1;
                    else d.tspd[q.cidx] = reg_wdata[23:0]; // RULE2 RULE4
                REG_CTIM: if (cell_bad) d.cell_err = 1'b1;
                    else d.ttim[q.cidx] = fix_tim(reg_wdata[7:0]); // RULE2 RULE5
                default: ;
            endcase
        end

        unique case (q.st)
            ST_IDLE: ;
            ST_ARMED: if (reg_wr && reg_addr == REG_CMD && reg_wdata[CMD_BEGIN]
                          && q.motor_on) begin
                d.st = ST_LOAD; // RULE12
                d.elap = '0;
            end
            ST_LOAD: begin
                // absolute end points, relative duration of the start row
                dp  = 40'($signed(q.tpos[r_nxt])) - 40'($signed(q.tpos[q.rptr])); // RULE23
                v0t = vsc(q.tspd[q.rptr], q.ttim[q.rptr]);
                v1t = vsc(q.tspd[r_nxt], q.ttim[q.rptr]);
                d.cd = q.tpos[q.rptr]; // RULE26 RULE22
                d.cc = v0t;
                d.cb = dp + dp + dp - v0t - v0t - v1t;
                d.ca = v0t + v1t - dp - dp;
                d.tns = 32'(q.ttim[q.rptr]) * TMS_NS_PER_MS;
                d.rem = {1'b0, q.elap};
                d.quo = '0;
                d.dcnt = '0;
                d.st = ST_DIV;
            end
            ST_WAIT: if (tick) begin
                if (adv) begin
                    d.elap = elap_n - q.tns; // RULE8
                    d.rptr = r_nxt; // RULE7
                    if (adv_uf) begin
                        d.uflow = 1'b1; // RULE20
                        d.ev = 1'b1;
                        d.ecode = EMCY_UFLOW;
                        d.st = ST_STOP; // RULE16
                    end else if (adv_end) begin
                        d.st = ST_STOP; // RULE10 RULE16
                    end else begin
                        d.st = ST_LOAD;
                    end
                end else begin
                    d.elap = elap_n; // RULE25
                    d.rem = {1'b0, elap_n};
                    d.quo = '0;
                    d.dcnt = '0;
                    d.st = ST_DIV;
                end
            end
            ST_DIV: begin
                // one quotient bit a cycle; far shorter than a sample period
                r2 = {q.rem[31:0], 1'b0};
                if (r2 >= {1'b0, q.tns}) begin
                    d.rem = r2 - {1'b0, q.tns};
                    d.quo = {q.quo[14:0], 1'b1};
                end else begin
                    d.rem = r2;
                    d.quo = {q.quo[14:0], 1'b0};
                end
                d.dcnt = q.dcnt + 5'h1;
                if (q.dcnt == DIV_LAST) d.st = ST_EVAL;
            end
            ST_EVAL: begin
                p = poly(q.ca, q.cb, q.cc, q.cd, q.quo); // RULE22 RULE8
                d.pos = p[31:0];
                d.vel = p[31:0] - q.pos;
                d.st = ST_WAIT;
            end
            ST_STOP: if (tick) begin
                // speed in counts per sample, ramped by the stop deceleration
                if ($signed(q.vel) > $signed({16'h0, q.sdec})) nv = $signed(q.vel) - $signed({16'h0, q.sdec});
                else if ($signed(q.vel) < -$signed({16'h0, q.sdec})) nv = $signed(q.vel) + $signed({16'h0, q.sdec});
                else nv = '0;
                d.vel = nv; // RULE16
                d.pos = q.pos + nv;
                if (q.vel == '0) d.st = ST_IDLE;
            end
            default: d.st = ST_IDLE;
        endcase

        if (running && q.auto_inc && q.qthr != '0) begin // RULE24
            if (remain < q.qthr) begin
                if (!q.qlow_seen && !d.ev) begin
                    d.ev = 1'b1; // RULE19 RULE20
                    d.ecode = EMCY_QLOW;
                end
                d.qlow_seen = 1'b1;
            end else begin
                d.qlow_seen = 1'b0;
            end
        end
        if (d.ev) begin
            d.erp = TMS_RW'(d.rptr) + 1'b1;
            d.ewp = TMS_RW'(d.wptr) + 1'b1;
        end

        if (q.flt[1] && q.motor_on) begin
            d.motor_on = 1'b0; // RULE14
            if (running) d.st = ST_STOP;
            else if (q.st == ST_ARMED) d.st = ST_IDLE;
        end
        if (reg_wr && reg_addr == REG_MOTOR && !reg_wdata[0]) d.st = ST_IDLE; // RULE14
        if (reg_wr && reg_addr == REG_CMD && reg_wdata[CMD_OTHER]) d.st = ST_IDLE; // RULE15

        if (reg_rd) begin
            unique case (reg_addr)
                REG_MOTOR:  d.rdata = {31'h0, q.motor_on};
                REG_START:  d.rdata = 32'(q.rptr) + 32'h1;
                REG_LOW:    d.rdata = 32'(q.low) + 32'h1;
                REG_HIGH:   d.rdata = 32'(q.high) + 32'h1;
                REG_MODE:   d.rdata = 32'({q.auto_inc, q.cyclic});
                REG_QLOW:   d.rdata = 32'(q.qthr);
                REG_WPTR:   d.rdata = 32'(q.wptr) + 32'h1;
                REG_SDEC:   d.rdata = 32'(q.sdec);
                REG_NODE:   d.rdata = 32'(q.node);
                REG_CIDX:   d.rdata = 32'(q.cidx) + 32'h1;
                REG_CPOS:   d.rdata = q.tpos[q.cidx]; // RULE2
                REG_CSPD:   d.rdata = 32'($signed(q.tspd[q.cidx]));
                REG_CTIM:   d.rdata = 32'(q.ttim[q.cidx]);
                REG_POSREF: d.rdata = q.pos;
                REG_STATUS: begin
                    d.rdata[STS_RUN]   = running;
                    d.rdata[STS_ARMED] = (q.st == ST_ARMED);
                    d.rdata[STS_STOP]  = (q.st == ST_STOP);
                    d.rdata[STS_CERR]  = q.cell_err;
                    d.rdata[STS_REJ]   = q.rej_err;
                    d.rdata[STS_UFLOW] = q.uflow;
                end
                default: d.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) q <= RST_Q; // RULE1
        else if (ce) q <= d;
    end

    assign reg_rdata     = q.rdata;
    assign pos_ref       = q.pos;
    assign motion_active = running;
    assign emcy_valid    = q.ev;
    assign emcy_code     = q.ecode;
    assign emcy_rptr     = q.erp;
    assign emcy_wptr     = q.ewp;

    // ==========================================================
    // checks
    default clocking cb_chk @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    chk_time_floor: assert property ( // RULE5
        (q.st == ST_WAIT) |-> (q.tns >= TMS_NS_PER_MS)) else $error("segment time under 1 ms");
    chk_pos_clamp: assert property ( // RULE3
        (ce && reg_wr && reg_addr == REG_CPOS) |=>
        ($signed(q.tpos[$past(q.cidx)]) <= TMS_POS_LIM)
        && ($signed(q.tpos[$past(q.cidx)]) >= -TMS_POS_LIM)) else $error("position out of range");
    chk_row_readback: assert property ( // RULE9
        (ce && reg_rd && reg_addr == REG_LOW) |=>
        (q.rdata == 32'($past(q.low)) + 32'h1)) else $error("low row readback wrong");
    chk_start_arm: assert property ( // RULE12
        (ce && reg_wr && reg_addr == REG_START && row_ok(reg_wdata) && !q.flt[1]) |=>
        (q.st == ST_ARMED) && (q.rptr == to_idx($past(reg_wdata)))) else $error("start row did not arm");
    chk_motor_off: assert property ( // RULE14
        (ce && reg_wr && reg_addr == REG_MOTOR && !reg_wdata[0]) |=>
        (q.st == ST_IDLE) && !motion_active) else $error("motion kept after motor off");
    chk_other_mode: assert property ( // RULE15
        (ce && reg_wr && reg_addr == REG_CMD && reg_wdata[CMD_OTHER]) |=>
        (q.st == ST_IDLE)) else $error("motion kept after mode change");
    chk_wptr_step: assert property ( // RULE18
        (ce && pdo_take && !pdo_bad && !(reg_wr && reg_addr == REG_WPTR)) |=>
        (q.wptr == nxt($past(q.wptr), $past(q.low), $past(q.high)))) else $error("write pointer not stepped");
    chk_uflow_emcy: assert property ( // RULE20
        (ce && adv && adv_uf) |=> q.ev && (q.ecode == EMCY_UFLOW)
        && (q.st != ST_LOAD)) else $error("underflow not reported");
    chk_exact_time: assert property ( // RULE8
        (ce && adv) |=> (q.elap == $past(elap_n) - $past(q.tns))) else $error("leftover time lost");
    chk_seg_guard: assert property ( // RULE13
        (ce && reg_wr && reg_addr == REG_CPOS && cell_bad) |=> q.cell_err) else $error("segment write not flagged");
    chk_load_coef: assert property ( // RULE26
        (ce && q.st == ST_LOAD) |=> (q.cd == q.tpos[$past(q.rptr)])
        && (q.st != ST_EVAL)) else $error("coefficients not ready");
endmodule : tms_sequencer

// ===== dv/tms_host_model.sv
// host side of the row message link: sends whole table rows as one message
// assumes the bench calls send_row from a process clocked by clk_sys
`timescale 1ns/1ps
module tms_host_model (
    input  wire logic        clk_sys,
    output logic             pdo_valid,
    output logic      [10:0] pdo_cob_id,
    output logic      [31:0] pdo_pos,
    output logic      [23:0] pdo_spd,
    output logic      [7:0]  pdo_tim
);
    // ==========================================================
    // row message
    initial begin
        {pdo_valid, pdo_cob_id, pdo_pos, pdo_spd, pdo_tim} = '0;
    end
    task automatic send_row(input logic [10:0] id, input logic [31:0] p);
        @(posedge clk_sys);
        pdo_valid  <= 1'b1;
        pdo_cob_id <= id;
        pdo_pos    <= p;
        pdo_spd    <= 24'h000000;
        pdo_tim    <= 8'h01;
        @(posedge clk_sys);
        pdo_valid  <= 1'b0;
        // the released position field must not keep looking valid
        pdo_pos    <= ~p;
    endtask : send_row
endmodule : tms_host_model

// ===== dv/tms_sequencer_tb_top.sv
// register-level bench for the sequencer with a row message host model
// assumes a fast sample period parameter; ce held high, fault pin driven here
`timescale 1ns/1ps
module tms_sequencer_tb_top;
    import tms_pkg::*;
    logic        clk_sys = 1'b0;
    logic        rstn = 1'b0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        fault_pin = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] reg_rdata, pos_ref, d;
    logic        motion_active, emcy_valid, pdo_valid;
    logic [1:0]  emcy_code;
    logic [6:0]  emcy_rptr, emcy_wptr;
    logic [10:0] pdo_cob_id;
    logic [31:0] pdo_pos;
    logic [23:0] pdo_spd;
    logic [7:0]  pdo_tim;
    int          bad_count = 0;
    int          n_compared = 0;
    always #25 clk_sys = ~clk_sys;
    tms_host_model hm (.clk_sys, .pdo_valid, .pdo_cob_id, .pdo_pos, .pdo_spd, .pdo_tim);
    tms_sequencer #(.SAMPLE_CYC(40)) uut (.clk_sys, .rstn, .ce(1'b1), .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pdo_valid, .pdo_cob_id, .pdo_pos,
        .pdo_spd, .pdo_tim, .fault_in(fault_pin), .pos_ref, .motion_active, .emcy_valid,
        .emcy_code, .emcy_rptr, .emcy_wptr);
    // ==========================================================
    // access tasks
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, v};
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : complete_run
    // ==========================================================
    // tests
    initial begin
        repeat (12) @(posedge clk_sys);
        rstn <= 1'b1;
        rd(REG_LOW);  chk("low row", 32'h1, d);
        rd(REG_HIGH); chk("high row", 32'h40, d);
        rd(8'hFC);    chk("unmapped", 32'h0, d);
        wr(REG_CIDX, 32'h5);
        wr(REG_CPOS, 32'h7FFF_FFFF); rd(REG_CPOS); chk("pos sat", 32'h4000_0000, d);
        wr(REG_CSPD, 32'h0080_0000); rd(REG_CSPD); chk("spd", 32'hFF80_0000, d);
        wr(REG_CTIM, 32'h0); rd(REG_CTIM); chk("time", 32'h1, d);
        $display("cell test done");
        wr(REG_NODE, 32'h2);
        wr(REG_WPTR, 32'hA);
        hm.send_row(11'h302, 32'h0000_0123);
        hm.send_row(11'h301, 32'h0000_0456);
        rd(REG_WPTR); chk("wptr", 32'hB, d);
        wr(REG_CIDX, 32'hA); rd(REG_CPOS); chk("msg row", 32'h123, d);
        $display("row message test done");
        wr(REG_CIDX, 32'h1); wr(REG_CPOS, 32'h1F4);
        wr(REG_CIDX, 32'h2); wr(REG_CPOS, 32'h3E8);
        wr(REG_HIGH, 32'h2);
        wr(REG_START, 32'h1); rd(REG_STATUS); chk("armed", 32'h2, d & 32'h3);
        wr(REG_MOTOR, 32'h1); wr(REG_CMD, 32'h1);
        repeat (40) @(posedge clk_sys);
        chk("run", 32'h1, motion_active);
        chk("first", 32'h1F4, pos_ref);
        wr(REG_CIDX, 32'h1); wr(REG_CPOS, 32'h0);
        rd(REG_STATUS); chk("cell err", 32'h8, d & 32'h8);
        rd(REG_CPOS); chk("kept", 32'h1F4, d);
        for (int k = 0; k < 30000 && motion_active !== 1'b0; k++) @(posedge clk_sys);
        chk("ended", 32'h0, motion_active);
        chk("end pos", 32'h1, pos_ref >= 990 && pos_ref <= 1000);
        rd(REG_START); chk("rptr", 32'h2, d);
        $display("motion test done");
        for (int m = 0; m < 2; m++) begin
            wr(REG_START, 32'h1); wr(REG_MOTOR, 32'h1); wr(REG_CMD, 32'h1);
            repeat (5) @(posedge clk_sys);
            if (m == 0) wr(REG_MOTOR, 32'h0);
            else wr(REG_CMD, 32'h2);
            @(posedge clk_sys);
            chk("stopped", 32'h0, motion_active);
        end
        wr(REG_START, 32'h1);
        fault_pin <= 1'b1;
        repeat (4) @(posedge clk_sys);
        fault_pin <= 1'b0;
        rd(REG_STATUS); chk("fault arm", 32'h0, d & 32'h3);
        rd(REG_MOTOR); chk("fault motor", 32'h0, d);
        $display("termination test done");
        // cyclic plus auto-increment: row 2 wraps to row 1, then the queue runs dry
        wr(REG_MODE, 32'h3); wr(REG_QLOW, 32'h2); wr(REG_WPTR, 32'h2);
        wr(REG_START, 32'h2); wr(REG_MOTOR, 32'h1); wr(REG_CMD, 32'h1);
        for (int k = 0; k < 99 && emcy_valid !== 1'b1; k++) @(posedge clk_sys);
        chk("qlow", 32'h4102, {emcy_code, emcy_rptr, emcy_wptr});
        repeat (10000) @(posedge clk_sys);
        chk("wrap", 32'h1, pos_ref > 700 && pos_ref < 800);
        for (int k = 0; k < 40000 && emcy_valid !== 1'b1; k++) @(posedge clk_sys);
        chk("uflow", 32'h8102, {emcy_code, emcy_rptr, emcy_wptr});
        chk("uflow stop", 32'h0, motion_active);
        rd(REG_STATUS); chk("uflow flag", 32'h20, d & 32'h20);
        $display("auto test done");
        complete_run();
    end
endmodule : tms_sequencer_tb_top
